// ==== hw/lsbd_pkg.sv ====
// Constants, types and opcode patterns for the logic, string and branch
// decoder. Assumes opcode bytes arrive one at a time from the fetch queue.
// What this block does
// - First byte 110100vw is the shift group; second-byte middle field picks operation.
// - First byte 1111011w: field 000 flag-only AND immediate, 010 invert.
// - AND, OR, XOR register forms 001000dw, 000010dw, 001100dw take a mode byte.
// - Flag-only AND writes no result; register form 1000010w takes a mode byte.
// - 1010100w is flag-only AND of accumulator with one or two data bytes.
// - 1010110w string load into low byte or word accumulator by size.
// - 1010101w string store from low byte or word accumulator by size.
// - Scan 1010111w, copy 1010010w, compare 1010011w, byte or word by low bit.
// - Jump 11101001 takes low then high displacement; 11101011 takes one byte.
// - 11000011 near return, 11001011 far return, no operand bytes follow.
// - 11000010 near return then adds 16-bit immediate to stack pointer.
// - 11001010 far return then adds 16-bit immediate to stack pointer.
// - 01111100 is branch if less with one displacement byte.
// - Carry rotations are distinct, field 010 left and 011 right.
// - Count-source bit clear means count one, set means count low byte.
// - Size bit one selects word, zero selects byte.
// - Direction bit set makes register field the destination.
// - Repeat prefix low bit is held as zero flag test value.
package lsbd_pkg;

    localparam logic [5:0] SHIFT_PAT     = 6'h34; // 110100
    localparam logic [6:0] UNARY_PAT     = 7'h7B; // 1111011
    localparam logic [5:0] AND_RM_PAT    = 6'h08; // 001000
    localparam logic [5:0] OR_RM_PAT     = 6'h02; // 000010
    localparam logic [5:0] XOR_RM_PAT    = 6'h0C; // 001100
    localparam logic [6:0] TEST_RM_PAT   = 7'h42; // 1000010
    localparam logic [6:0] TEST_ACC_PAT  = 7'h54; // 1010100
    localparam logic [6:0] LOAD_PAT      = 7'h56; // 1010110
    localparam logic [6:0] STORE_PAT     = 7'h55; // 1010101
    localparam logic [6:0] SCAN_PAT      = 7'h57; // 1010111
    localparam logic [6:0] COPY_PAT      = 7'h52; // 1010010
    localparam logic [6:0] COMPARE_PAT   = 7'h53; // 1010011
    localparam logic [6:0] PREFIX_PAT    = 7'h79; // 1111001
    localparam logic [7:0] JMP_NEAR_OP   = 8'hE9;
    localparam logic [7:0] JMP_SHORT_OP  = 8'hEB;
    localparam logic [7:0] RET_NEAR_OP   = 8'hC3;
    localparam logic [7:0] RET_NEAR_IMM  = 8'hC2;
    localparam logic [7:0] RET_FAR_OP    = 8'hCB;
    localparam logic [7:0] RET_FAR_IMM   = 8'hCA;
    localparam logic [7:0] BR_EQUAL_OP   = 8'h74;
    localparam logic [7:0] BR_LESS_OP    = 8'h7C;

    // Middle field (bits 5..3) of the second byte.
    localparam logic [2:0] FLD_ROL  = 3'h0;
    localparam logic [2:0] FLD_ROR  = 3'h1;
    localparam logic [2:0] FLD_RCL  = 3'h2;
    localparam logic [2:0] FLD_RCR  = 3'h3;
    localparam logic [2:0] FLD_SHL  = 3'h4;
    localparam logic [2:0] FLD_SHR  = 3'h5;
    localparam logic [2:0] FLD_SAR  = 3'h7;
    localparam logic [2:0] FLD_TEST = 3'h0;
    localparam logic [2:0] FLD_NOT  = 3'h2;

    typedef enum logic [4:0] {
        OP_NONE          = 5'h00,
        OP_ROTATE_LEFT   = 5'h01,
        OP_ROTATE_RIGHT  = 5'h02,
        OP_ROTATE_CLEFT  = 5'h03,
        OP_ROTATE_CRIGHT = 5'h04,
        OP_SHIFT_LEFT    = 5'h05,
        OP_LSHIFT_RIGHT  = 5'h06,
        OP_ASHIFT_RIGHT  = 5'h07,
        OP_INVERT        = 5'h08,
        OP_AND           = 5'h09,
        OP_OR            = 5'h0A,
        OP_XOR           = 5'h0B,
        OP_FLAG_AND      = 5'h0C,
        OP_STRING_LOAD   = 5'h0D,
        OP_STRING_STORE  = 5'h0E,
        OP_SCAN_STRING   = 5'h0F,
        OP_STRING_COPY   = 5'h10,
        OP_STRING_CMP    = 5'h11,
        OP_BRANCH        = 5'h12,
        OP_EXIT_NEAR     = 5'h13,
        OP_EXIT_FAR      = 5'h14,
        OP_BR_EQUAL      = 5'h15,
        OP_BR_LESS       = 5'h16,
        OP_ILLEGAL       = 5'h1F
    } lsbd_op_e;

    typedef enum logic [2:0] {
        ST_OPCODE  = 3'h0,
        ST_MODE    = 3'h1,
        ST_LOW     = 3'h2,
        ST_HIGH    = 3'h3,
        ST_PRESENT = 3'h4
    } lsbd_state_e;

    // Decoded instruction handed to execution.
    typedef struct packed {
        lsbd_op_e    op;
        logic        isWord;      // Word operand when set.
        logic        regIsDest;   // Register field is destination when set.
        logic        countFromCl; // Count from count_low_byte when set.
        logic        writesResult;
        logic        addStackPtr; // Add operand to stack_pointer after exit.
        logic        repeatOn;
        logic        repeatZero;  // Zero flag value tested by compare/scan.
        logic [7:0]  modeByte;
        logic [15:0] operand;
    } lsbd_instr_s;

    // Length summary for one opcode.
    typedef struct packed {
        lsbd_op_e   op;
        logic       needsMode;
        logic [1:0] extraBytes;  // Bytes after opcode and mode byte.
        logic [1:0] totalFollow; // All bytes after the opcode.
    } lsbd_len_s;

endpackage : lsbd_pkg

// ==== hw/lsbd_first_byte.sv ====
// Combinational classification of an opcode byte.
// Assumes the caller supplies the second byte once it is known.
`timescale 1ns/1ps
module lsbd_first_byte
(
    // Opcode and mode bytes.
    input  wire logic [7:0]         opByte,
    input  wire logic [7:0]         modeByte,
    // Classification result.
    output lsbd_pkg::lsbd_len_s     lenInfo
);
    import lsbd_pkg::*;

    // Pattern matches on the first byte.
    wire       isShift  = (opByte[7:2] == SHIFT_PAT);
    wire       isUnary  = (opByte[7:1] == UNARY_PAT);
    wire       isAndRm  = (opByte[7:2] == AND_RM_PAT);
    wire       isOrRm   = (opByte[7:2] == OR_RM_PAT);
    wire       isXorRm  = (opByte[7:2] == XOR_RM_PAT);
    wire       isTestRm = (opByte[7:1] == TEST_RM_PAT);
    wire       isTestAc = (opByte[7:1] == TEST_ACC_PAT);
    wire [2:0] midField = modeByte[5:3];
    wire       wordBit  = opByte[0];
    wire [1:0] dataLen  = wordBit ? 2'h2 : 2'h1;

    // Operation selection for the shift group and unary group.
    lsbd_op_e shiftOp;
    lsbd_op_e unaryOp;
    always_comb
    begin
        case (midField)
            FLD_ROL: shiftOp = OP_ROTATE_LEFT;
            FLD_ROR: shiftOp = OP_ROTATE_RIGHT;
            FLD_RCL: shiftOp = OP_ROTATE_CLEFT;
            FLD_RCR: shiftOp = OP_ROTATE_CRIGHT;
            FLD_SHL: shiftOp = OP_SHIFT_LEFT;
            FLD_SHR: shiftOp = OP_LSHIFT_RIGHT;
            FLD_SAR: shiftOp = OP_ASHIFT_RIGHT;
            default: shiftOp = OP_ILLEGAL;
        endcase
        case (midField)
            FLD_TEST: unaryOp = OP_FLAG_AND;
            FLD_NOT:  unaryOp = OP_INVERT;
            default:  unaryOp = OP_ILLEGAL;
        endcase
    end

    // Length and operation lookup.
    always_comb
    begin
        lenInfo = '{op: OP_ILLEGAL, needsMode: 1'b0,
                    extraBytes: 2'h0, totalFollow: 2'h0};
        if (isShift)
        begin
            lenInfo.op = shiftOp;
            lenInfo.needsMode = 1'b1;
        end
        else if (isUnary)
        begin
            lenInfo.op = unaryOp;
            lenInfo.needsMode = 1'b1;
            lenInfo.extraBytes = (unaryOp == OP_FLAG_AND) ? dataLen
                                                         : 2'h0;
        end
        else if (isAndRm | isOrRm | isXorRm | isTestRm)
        begin
            lenInfo.needsMode = 1'b1;
            lenInfo.op = isAndRm ? OP_AND : isOrRm ? OP_OR :
                         isXorRm ? OP_XOR : OP_FLAG_AND;
        end
        else if (isTestAc)
        begin
            lenInfo.op = OP_FLAG_AND;
            lenInfo.extraBytes = dataLen;
        end
        else
        begin
            case (opByte[7:1])
                LOAD_PAT:    lenInfo.op = OP_STRING_LOAD;
                STORE_PAT:   lenInfo.op = OP_STRING_STORE;
                SCAN_PAT:    lenInfo.op = OP_SCAN_STRING;
                COPY_PAT:    lenInfo.op = OP_STRING_COPY;
                COMPARE_PAT: lenInfo.op = OP_STRING_CMP;
                default:
                begin
                    case (opByte)
                        JMP_NEAR_OP:
                        begin
                            lenInfo.op = OP_BRANCH;
                            lenInfo.extraBytes = 2'h2;
                        end
                        JMP_SHORT_OP:
                        begin
                            lenInfo.op = OP_BRANCH;
                            lenInfo.extraBytes = 2'h1;
                        end
                        RET_NEAR_OP: lenInfo.op = OP_EXIT_NEAR;
                        RET_FAR_OP:  lenInfo.op = OP_EXIT_FAR;
                        RET_NEAR_IMM:
                        begin
                            lenInfo.op = OP_EXIT_NEAR;
                            lenInfo.extraBytes = 2'h2;
                        end
                        RET_FAR_IMM:
                        begin
                            lenInfo.op = OP_EXIT_FAR;
                            lenInfo.extraBytes = 2'h2;
                        end
                        BR_EQUAL_OP:
                        begin
                            lenInfo.op = OP_BR_EQUAL;
                            lenInfo.extraBytes = 2'h1;
                        end
                        BR_LESS_OP:
                        begin
                            lenInfo.op = OP_BR_LESS;
                            lenInfo.extraBytes = 2'h1;
                        end
                        default: lenInfo.op = OP_ILLEGAL;
                    endcase
                end
            endcase
        end
        // Mode byte counts as one following byte.
        lenInfo.totalFollow = 2'(lenInfo.extraBytes
                                 + {1'b0, lenInfo.needsMode});
    end

endmodule : lsbd_first_byte

// ==== hw/logic_string_branch_decoder.sv ====
// Top of the decoder: collects opcode, mode and operand bytes and presents
// one decoded instruction. Assumes a valid/ready byte stream from the fetch
// queue and a ready signal from execution.
`timescale 1ns/1ps
module logic_string_branch_decoder
(
    // Clock and reset.
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    // Byte stream from fetch.
    input  wire logic [7:0]           fetchByte,
    input  wire logic                 fetchValid,
    output logic                      fetchReady,
    // Length report to fetch at opcode time.
    output logic                      lenValid,
    output logic [1:0]                lenFollow,
    // Decoded instruction to execution.
    output lsbd_pkg::lsbd_instr_s     instr,
    output logic                      instrValid,
    input  wire logic                 execReady
);
    import lsbd_pkg::*;

    lsbd_state_e state;
    lsbd_state_e next_state;
    logic [7:0]  opByte;
    logic [1:0]  remaining;
    logic        prefixSeen;
    logic        prefixZero;
    lsbd_len_s   lenNow;
    lsbd_instr_s next_instr;

    // Classify the live byte at opcode time, the held byte afterwards.
    wire         atOpcode = (state == ST_OPCODE);
    wire [7:0]   classByte = atOpcode ? fetchByte : opByte;
    wire         take = fetchValid & fetchReady;
    wire         isPrefix = (fetchByte[7:1] == PREFIX_PAT);
    // Flag-only forms write nothing back. Group ops settle only once the
    // mode byte is seen, so this is applied at both capture steps.
    wire         noResult = (lenNow.op == OP_FLAG_AND)
                          | (lenNow.op == OP_STRING_CMP)
                          | (lenNow.op == OP_SCAN_STRING)
                          | (lenNow.op == OP_BR_EQUAL)
                          | (lenNow.op == OP_BR_LESS);

    lsbd_first_byte u_first
    (
        .opByte   (classByte),
        .modeByte (fetchByte),
        .lenInfo  (lenNow)
    );

    // Mode byte sits in the fetch slot when its state is live.
    assign fetchReady = (state != ST_PRESENT);
    assign instrValid = (state == ST_PRESENT);
    assign lenValid   = atOpcode & fetchValid & ~isPrefix;
    assign lenFollow  = lenNow.totalFollow;

    // Next-state selection.
    always_comb
    begin
        next_state = state;
        case (state)
            ST_OPCODE:
                if (take & ~isPrefix)
                    next_state = lenNow.needsMode ? ST_MODE :
                                 (lenNow.extraBytes != 2'h0) ? ST_LOW :
                                 ST_PRESENT;
            ST_MODE:
                if (take)
                    next_state = (lenNow.extraBytes != 2'h0) ? ST_LOW
                                                             : ST_PRESENT;
            ST_LOW:
                if (take)
                    next_state = (remaining == 2'h2) ? ST_HIGH : ST_PRESENT;
            ST_HIGH:
                if (take)
                    next_state = ST_PRESENT;
            ST_PRESENT:
                if (execReady)
                    next_state = ST_OPCODE;
            default:
                next_state = ST_OPCODE;
        endcase
    end

    // Field capture for the presented instruction.
    always_comb
    begin
        next_instr = instr;
        case (state)
            ST_OPCODE:
                if (take & ~isPrefix)
                begin
                    next_instr.op           = lenNow.op;
                    next_instr.isWord       = fetchByte[0];
                    next_instr.regIsDest    = fetchByte[1];
                    next_instr.countFromCl  = fetchByte[1];
                    next_instr.writesResult = ~noResult;
                    next_instr.addStackPtr  = (fetchByte == RET_NEAR_IMM)
                                            | (fetchByte == RET_FAR_IMM);
                    next_instr.repeatOn     = prefixSeen;
                    next_instr.repeatZero   = prefixZero;
                    next_instr.modeByte     = 8'h00;
                    next_instr.operand      = 16'h0000;
                end
            ST_MODE:
                if (take)
                begin
                    next_instr.op       = lenNow.op;
                    next_instr.writesResult = ~noResult;
                    next_instr.modeByte = fetchByte;
                end
            ST_LOW:
                if (take)
                    next_instr.operand = {8'h00, fetchByte};
            ST_HIGH:
                if (take)
                    next_instr.operand[15:8] = fetchByte;
            default:
                next_instr = instr;
        endcase
    end

    // State, byte counters and the repeat prefix hold.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state      <= ST_OPCODE;
            opByte     <= 8'h00;
            remaining  <= 2'h0;
            prefixSeen <= 1'b0;
            prefixZero <= 1'b0;
            instr      <= '0;
        end
        else
        begin
            state <= next_state;
            instr <= next_instr;
            if (atOpcode & take)
            begin
                opByte <= fetchByte;
                remaining <= lenNow.extraBytes;
            end
            else if ((state == ST_MODE) & take)
                remaining <= lenNow.extraBytes;
            if (atOpcode & take & isPrefix)
            begin
                prefixSeen <= 1'b1;
                prefixZero <= fetchByte[0];
            end
            else if ((state == ST_PRESENT) & execReady)
                prefixSeen <= 1'b0;
        end
    end

endmodule : logic_string_branch_decoder

// ==== sim/lsbd_properties.sv ====
// Port checker for the decoder: length reports and instruction hand-off.
// Assumes it is bound to logic_string_branch_decoder.
`timescale 1ns/1ps
module lsbd_properties
(
    // Clock and reset.
    input wire logic                  core_clk,
    input wire logic                  reset,
    // Fetch side.
    input wire logic [7:0]            fetchByte,
    input wire logic                  fetchValid,
    input wire logic                  fetchReady,
    input wire logic                  lenValid,
    input wire logic [1:0]            lenFollow,
    // Execution side.
    input wire lsbd_pkg::lsbd_instr_s instr,
    input wire logic                  instrValid,
    input wire logic                  execReady
);
    import lsbd_pkg::*;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // An opcode byte is taken at this edge.
    logic takeOp;
    assign takeOp = lenValid && fetchReady && fetchValid;

    // Length reports per opcode family, then the hand-off to execution.
    a_near_jump_len: assert property (takeOp && fetchByte == JMP_NEAR_OP
        |-> lenFollow == 2'h2) else $error("near jump length wrong");
    a_cond_branch_len: assert property (takeOp &&
        (fetchByte == BR_EQUAL_OP || fetchByte == BR_LESS_OP)
        |-> lenFollow == 2'h1) else $error("branch length wrong");
    a_exit_imm_len: assert property (takeOp &&
        (fetchByte == RET_NEAR_IMM || fetchByte == RET_FAR_IMM)
        |-> lenFollow == 2'h2) else $error("exit immediate length wrong");
    a_exit_answer: assert property (takeOp &&
        (fetchByte == RET_NEAR_OP || fetchByte == RET_FAR_OP)
        |-> lenFollow == 2'h0 ##1 instrValid) else $error("plain exit wrong");
    a_logic_mode_len: assert property (takeOp &&
        (fetchByte[7:2] == AND_RM_PAT || fetchByte[7:2] == OR_RM_PAT ||
         fetchByte[7:2] == XOR_RM_PAT || fetchByte[7:2] == SHIFT_PAT)
        |-> lenFollow == 2'h1) else $error("mode byte length wrong");
    a_test_acc_len: assert property (takeOp &&
        fetchByte[7:1] == TEST_ACC_PAT
        |-> lenFollow == (fetchByte[0] ? 2'h2 : 2'h1))
        else $error("accumulator test length wrong");
    a_string_len: assert property (takeOp &&
        (fetchByte[7:1] == SCAN_PAT || fetchByte[7:1] == COPY_PAT ||
         fetchByte[7:1] == COMPARE_PAT || fetchByte[7:1] == LOAD_PAT ||
         fetchByte[7:1] == STORE_PAT) |-> lenFollow == 2'h0 ##1 instrValid)
        else $error("string length wrong");
    a_instr_stands: assert property (instrValid && !execReady
        |=> instrValid && $stable(instr)) else $error("instr not held");
    a_ready_presenting: assert property (instrValid |-> !fetchReady)
        else $error("byte accepted while presenting");
    a_return_opcode: assert property (instrValid && execReady
        |=> !instrValid && fetchReady) else $error("no return to opcode");

    // Main scenarios seen.
    c_near_jump: cover property (takeOp && fetchByte == JMP_NEAR_OP);
    c_held: cover property (instrValid && !execReady ##1 instrValid);
    c_repeat: cover property (instrValid && instr.repeatOn);
endmodule : lsbd_properties

bind logic_string_branch_decoder lsbd_properties u_props (
    .core_clk(core_clk), .reset(reset), .fetchByte(fetchByte),
    .fetchValid(fetchValid), .fetchReady(fetchReady),
    .lenValid(lenValid), .lenFollow(lenFollow), .instr(instr),
    .instrValid(instrValid), .execReady(execReady));

// ==== sim/lsbd_fetch_model.sv ====
// Behavioural fetch queue feeding opcode bytes to the decoder.
// Assumes the bench pushes bytes and drives stall off the rising edge.
`timescale 1ns/1ps
module lsbd_fetch_model
(
    // Clock and reset.
    input  wire logic  core_clk,
    input  wire logic  reset,
    // Pacing from the bench.
    input  wire logic  stall,
    // Byte stream to the decoder.
    input  wire logic  fetchReady,
    output logic [7:0] fetchByte,
    output logic       fetchValid
);
    logic [7:0] queue [$];
    logic       taken;
    logic       phase;

    // Adds one byte to the tail of the queue.
    task automatic push(input logic [7:0] b);
        queue.push_back(b);
    endtask : push

    // Idle values at time zero.
    initial
    begin
        fetchByte  = 8'hA5;
        fetchValid = 1'b0;
        taken      = 1'b0;
        phase      = 1'b0;
    end

    // Retires the head byte on the edge where the decoder takes it.
    always @(posedge core_clk)
    begin
        if (!reset && fetchValid && fetchReady)
        begin
            queue.delete(0);
            taken = 1'b1;
        end
    end

    // Holds an untaken byte; else offers the next, or idles with a
    // changing byte so a stale value is never mistaken for data.
    always @(negedge core_clk)
    begin
        phase = ~phase;
        if (!(fetchValid && !taken))
        begin
            if (queue.size() > 0 && !(stall && phase))
            begin
                fetchByte  = queue[0];
                fetchValid = 1'b1;
            end
            else
            begin
                fetchByte  = ~fetchByte;
                fetchValid = 1'b0;
            end
        end
        taken = 1'b0;
    end
endmodule : lsbd_fetch_model

// ==== sim/logic_string_branch_decoder_tb.sv ====
// Self-checking bench for the logic, string and branch decoder.
// Assumes the fetch model and the bound port checker are compiled first.
`timescale 1ns/1ps
module logic_string_branch_decoder_tb;
    import lsbd_pkg::*;

    localparam logic [2:0]  NOLEN = 3'h4;
    localparam logic [16:0] NOOPD = 17'h10000;
    localparam lsbd_op_e SHOPS [8] = '{OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
        OP_ROTATE_CLEFT, OP_ROTATE_CRIGHT, OP_SHIFT_LEFT,
        OP_LSHIFT_RIGHT, OP_ILLEGAL, OP_ASHIFT_RIGHT};
    localparam logic [7:0] STRB [7] = '{8'hAC, 8'hAD, 8'hAA, 8'hAB,
        8'hAE, 8'hA5, 8'hA6};
    localparam lsbd_op_e STROP [7] = '{OP_STRING_LOAD, OP_STRING_LOAD,
        OP_STRING_STORE, OP_STRING_STORE, OP_SCAN_STRING,
        OP_STRING_COPY, OP_STRING_CMP};

    logic        core_clk;
    logic        reset;
    logic [7:0]  fetchByte;
    logic        fetchValid;
    logic        fetchReady;
    logic        lenValid;
    logic [1:0]  lenFollow;
    lsbd_instr_s instr;
    logic        instrValid;
    logic        execReady;
    logic        stall;
    logic [1:0]  lastLen;
    lsbd_instr_s got;
    int          bad_count = 0;
    int          n_compared = 0;

    logic_string_branch_decoder dut (.core_clk(core_clk), .reset(reset),
        .fetchByte(fetchByte), .fetchValid(fetchValid),
        .fetchReady(fetchReady), .lenValid(lenValid),
        .lenFollow(lenFollow), .instr(instr), .instrValid(instrValid),
        .execReady(execReady));
    lsbd_fetch_model fq (.core_clk(core_clk), .reset(reset),
        .stall(stall), .fetchReady(fetchReady), .fetchByte(fetchByte),
        .fetchValid(fetchValid));

    // Free-running clock of 50 ns.
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Keeps the length reported when each opcode is taken.
    always @(posedge core_clk)
    begin
        if (lenValid && fetchReady && fetchValid)
            lastLen <= lenFollow;
    end

    // Prints the counts and the verdict, then stops.
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    // Counts one comparison and reports a mismatch.
    task automatic cmp(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    // Sends n bytes, waits for the result, holds it, then accepts it.
    task automatic run(input logic [31:0] bs, input int n,
                       input lsbd_op_e op, input logic [2:0] len,
                       input logic [16:0] opd);
        int k;
        for (k = 0; k < n; k++)
            fq.push(bs[31-8*k -: 8]);
        k = 0;
        while (instrValid !== 1'b1 && k < 40)
        begin
            @(negedge core_clk);
            k++;
        end
        if (instrValid !== 1'b1)
        begin
            bad_count++;
            $display("BAD instrValid expected 1 seen %b", instrValid);
            finish_test();
        end
        repeat (2) @(negedge core_clk);
        got = instr;
        cmp("op", 16'(op), 16'(got.op));
        if (!len[2])
            cmp("lenFollow", 16'(len[1:0]), 16'(lastLen));
        if (!opd[16])
            cmp("operand", opd[15:0], got.operand);
        execReady = 1'b1;
        @(negedge core_clk);
        execReady = 1'b0;
    endtask : run

    // Every shift field once, count-source and size bits taken from the field's low two bits.
    task automatic sc_shift;
        int         f;
        logic [7:0] opc;
        for (f = 0; f < 8; f++)
        begin
            opc = 8'hD0 | 8'(f[1:0]);
            run({opc, 8'hC0 | 8'(f << 3), 16'h0}, 2, SHOPS[f], 3'h1, NOOPD);
            cmp("countFromCl", 16'(opc[1]), 16'(got.countFromCl));
            cmp("isWord", 16'(opc[0]), 16'(got.isWord));
        end
    endtask : sc_shift

    // Flag-only AND with word immediate, byte inversion, logic forms.
    task automatic sc_logic;
        run(32'hF7C03412, 4, OP_FLAG_AND, NOLEN, 17'h01234);
        cmp("writesResult", 16'h0, 16'(got.writesResult));
        run(32'hF6D00000, 2, OP_INVERT, NOLEN, NOOPD);
        cmp("isWord", 16'h0, 16'(got.isWord));
        run(32'h20C00000, 2, OP_AND, 3'h1, NOOPD);
        cmp("regIsDest", 16'h0, 16'(got.regIsDest));
        cmp("writesResult", 16'h1, 16'(got.writesResult));
        run(32'h0BC80000, 2, OP_OR, 3'h1, NOOPD);
        cmp("regIsDest", 16'h1, 16'(got.regIsDest));
        cmp("modeByte", 16'h00C8, 16'(got.modeByte));
        run(32'h33D80000, 2, OP_XOR, 3'h1, NOOPD);
        run(32'h85C00000, 2, OP_FLAG_AND, 3'h1, NOOPD);
        cmp("writesResult", 16'h0, 16'(got.writesResult));
    endtask : sc_logic

    // Accumulator test, all string primitives, both repeat prefixes.
    task automatic sc_string;
        int i;
        stall = 1'b1;
        run(32'hA85A0000, 2, OP_FLAG_AND, 3'h1, 17'h0005A);
        run(32'hA9341200, 3, OP_FLAG_AND, 3'h2, 17'h01234);
        stall = 1'b0;
        for (i = 0; i < 7; i++)
        begin
            run({STRB[i], 24'h0}, 1, STROP[i], 3'h0, NOOPD);
            cmp("isWord", 16'(STRB[i][0]), 16'(got.isWord));
            cmp("repeatOn", 16'h0, 16'(got.repeatOn));
        end
        run(32'hF3A60000, 2, OP_STRING_CMP, 3'h0, NOOPD);
        cmp("repeatZero", 16'h1, 16'(got.repeatZero));
        run(32'hF2AF0000, 2, OP_SCAN_STRING, 3'h0, NOOPD);
        cmp("repeatOn", 16'h1, 16'(got.repeatOn));
        cmp("repeatZero", 16'h0, 16'(got.repeatZero));
    endtask : sc_string

    // Jumps, exits back to back, exits with stack adjust, branches.
    task automatic sc_branch;
        run(32'hE9341200, 3, OP_BRANCH, 3'h2, 17'h01234);
        run(32'hEB7F0000, 2, OP_BRANCH, 3'h1, 17'h0007F);
        run(32'hC3CB0000, 2, OP_EXIT_NEAR, 3'h0, NOOPD);
        run(32'h0, 0, OP_EXIT_FAR, 3'h0, NOOPD);
        cmp("addStackPtr", 16'h0, 16'(got.addStackPtr));
        run(32'hC2080000, 3, OP_EXIT_NEAR, 3'h2, 17'h00008);
        cmp("addStackPtr", 16'h1, 16'(got.addStackPtr));
        run(32'hCA100200, 3, OP_EXIT_FAR, 3'h2, 17'h00210);
        cmp("addStackPtr", 16'h1, 16'(got.addStackPtr));
        run(32'h74100000, 2, OP_BR_EQUAL, 3'h1, 17'h00010);
        run(32'h7CF00000, 2, OP_BR_LESS, 3'h1, 17'h000F0);
    endtask : sc_branch

    // Reset, then every scenario in turn.
    initial
    begin
        reset = 1'b1;
        execReady = 1'b0;
        stall = 1'b0;
        repeat (12) @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
        cmp("fetchReady", 16'h1, 16'(fetchReady));
        sc_shift();
        sc_logic();
        sc_string();
        sc_branch();
        finish_test();
    end
endmodule : logic_string_branch_decoder_tb
